// [include/ucb_pkg.sv]
package ucb_pkg;
	// ---------------------------------------------------------------
	// Setup packet fields
	// ---------------------------------------------------------------
	localparam logic [7:0] REQ_TYPE_CLASS_OUT = 8'h21;
	localparam logic [7:0] REQ_SET_REPORT     = 8'h09;
	localparam logic [7:0] REQ_INDEX_IFACE    = 8'h03;

	// ---------------------------------------------------------------
	// Packet byte 0 encoding
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_READ       = 8'h00;
	localparam logic [7:0] OP_WRITE      = 8'h10;
	localparam logic [7:0] SEL_GPIO      = 8'h08;
	localparam logic [7:0] SEL_SPI16     = 8'h04;
	localparam logic [7:0] SEL_I2C_FAST  = 8'h02;
	localparam logic [7:0] SEL_I2C_STANDARD_SELECT   = 8'h01;
	localparam logic [7:0] SEL_SPI8      = 8'h00;
	localparam logic [7:0] FLAG_DONE     = 8'h20;
	localparam logic [7:0] FLAG_BUS_FAIL = 8'h40;
	localparam logic [7:0] FLAG_BAD_REQ  = 8'h80;

	// ---------------------------------------------------------------
	// Packet layout
	// ---------------------------------------------------------------
	localparam int         PKT_MAX      = 64;
	localparam int         DATA_MAX     = 60;
	localparam int         DATA_START   = 4;
	localparam int         RESP_MAX     = 42;
	localparam logic [6:0] GPIO_MASK    = 7'h7F;

	// ---------------------------------------------------------------
	// Timing at 10 MHz
	// ---------------------------------------------------------------
	localparam int CLK_HZ       = 10_000_000;
	localparam int I2C_STANDARD_SELECT_HZ   = 100_000;
	localparam int I2C_FAST_HZ  = 400_000;
	localparam int SPI_HZ       = 1_000_000;
	localparam int I2C_STANDARD_SELECT_DIV  = CLK_HZ / (4 * I2C_STANDARD_SELECT_HZ);
	localparam int I2C_FAST_DIV = CLK_HZ / (4 * I2C_FAST_HZ);
	localparam int SPI_DIV      = CLK_HZ / (4 * SPI_HZ);
endpackage

// [rtl/ucb_serial_engine.sv]
`timescale 1ns/1ps
// Bit engine: one I2C start, stop or byte, or one SPI byte, per command, quarter-bit timed
module ucb_serial_engine (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// Command
	input  wire logic       cmd_go,
	input  wire logic [2:0] cmd_kind,
	input  wire logic       cmd_fast,
	input  wire logic [7:0] cmd_byte,
	output logic            cmd_done,
	output logic [7:0]      cmd_rx,
	output logic            cmd_nack,
	// I2C pins, enable low drives low
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe_n,
	output logic            sda_oe_n,
	// SPI pins
	output logic            spi_sclk,
	output logic            spi_mosi,
	input  wire logic       spi_miso
);
	// Kinds: 0 start, 1 stop, 2 i2c write, 3 i2c read ack, 4 i2c read nack, 5 spi
	logic [7:0] div_cnt;
	logic [7:0] div_top;
	logic [1:0] phase;
	logic [3:0] bit_idx;
	logic       busy;
	logic [7:0] sh;
	logic [2:0] kind;
	logic       tick;
	logic       last_bit;

	assign div_top  = kind == 3'd5 ? 8'(ucb_pkg::SPI_DIV - 1) :
		cmd_fast ? 8'(ucb_pkg::I2C_FAST_DIV - 1) : 8'(ucb_pkg::I2C_STANDARD_SELECT_DIV - 1);
	assign tick     = busy && div_cnt == div_top;
	assign last_bit = (kind <= 3'd1) ? 1'b1 : (kind == 3'd5 ? bit_idx == 4'd7 : bit_idx == 4'd8);

	always_ff @(posedge clk_sys) begin
		if (srst || !busy || tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			busy     <= 1'b0;
			cmd_done <= 1'b0;
			phase    <= 2'd0;
			bit_idx  <= 4'd0;
			sh       <= 8'h00;
			kind     <= 3'd0;
			cmd_rx   <= 8'h00;
			cmd_nack <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			spi_sclk <= 1'b0;
			spi_mosi <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			if (cmd_go && !busy) begin
				busy    <= 1'b1;
				kind    <= cmd_kind;
				sh      <= cmd_byte;
				phase   <= 2'd0;
				bit_idx <= 4'd0;
			end else if (tick) begin
				phase <= phase + 2'd1;
				unique case (kind)
				3'd0: begin
					if (phase == 2'd0) begin
						sda_oe_n <= 1'b1;
					end else if (phase == 2'd1) begin
						scl_oe_n <= 1'b1;
					end else if (phase == 2'd2) begin
						sda_oe_n <= 1'b0;
					end else begin
						scl_oe_n <= 1'b0;
					end
				end
				3'd1: begin
					if (phase == 2'd0) begin
						sda_oe_n <= 1'b0;
					end else if (phase == 2'd1) begin
						scl_oe_n <= 1'b1;
					end else if (phase == 2'd2) begin
						sda_oe_n <= 1'b1;
					end
				end
				3'd5: begin
					if (phase == 2'd0) begin
						spi_mosi <= sh[7];
					end else if (phase == 2'd1) begin
						spi_sclk <= 1'b1;
						sh       <= {sh[6:0], spi_miso};
					end else if (phase == 2'd3) begin
						spi_sclk <= 1'b0;
					end
				end
				default: begin
					if (phase == 2'd0) begin
						if (bit_idx == 4'd8) begin
							sda_oe_n <= kind == 3'd3 ? 1'b0 : 1'b1;
						end else begin
							sda_oe_n <= kind == 3'd2 ? sh[7] : 1'b1;
						end
					end else if (phase == 2'd1) begin
						scl_oe_n <= 1'b1;
					end else if (phase == 2'd2 && scl_in) begin
						if (bit_idx == 4'd8) begin
							cmd_nack <= kind == 3'd2 ? sda_in : 1'b0;
						end else begin
							sh <= {sh[6:0], sda_in};
						end
					end else if (phase == 2'd3) begin
						scl_oe_n <= 1'b0;
					end
				end
				endcase
				if (phase == 2'd3) begin
					bit_idx <= bit_idx + 4'd1;
					if (last_bit) begin
						busy     <= 1'b0;
						cmd_done <= 1'b1;
						// Start and stop keep the last byte's data
						if (kind >= 3'd2) begin
							cmd_rx <= kind == 3'd2 ? cmd_byte : sh;
						end
						if (kind == 3'd2 && bit_idx == 4'd8) begin
							sda_oe_n <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule

// [rtl/ucb_command_bridge.sv]
`timescale 1ns/1ps
module ucb_command_bridge (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// Control endpoint setup and data stage
	input  wire logic       setup_valid,
	input  wire logic [7:0] setup_req_type,
	input  wire logic [7:0] setup_request,
	input  wire logic [7:0] setup_index,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_last,
	output logic            rx_ready,
	// Interrupt IN response stream
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	output logic            tx_last,
	input  wire logic       tx_ready,
	// I2C pins, enable low drives low
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe_n,
	output logic            sda_oe_n,
	// SPI pins
	output logic            spi_sclk,
	output logic            spi_mosi,
	output logic            spi_cs_n,
	input  wire logic       spi_miso,
	// GPIO lines
	input  wire logic [6:0] gpio_in,
	output logic [6:0]      gpio_out,
	output logic            busy
);
	typedef enum logic [2:0] {
		UCB_IDLE  = 3'b000,
		UCB_RECV  = 3'b001,
		UCB_RUN   = 3'b010,
		UCB_WAIT  = 3'b011,
		UCB_SEND  = 3'b100
	} ucb_state_e;

	// ---------------------------------------------------------------
	// Packet store and control
	// ---------------------------------------------------------------
	ucb_state_e state;
	logic [7:0] pkt [ucb_pkg::PKT_MAX];
	logic [6:0] wr_idx;
	logic [6:0] rd_idx;
	logic [6:0] tx_len;
	logic [5:0] step;
	logic       armed;
	logic       failed;
	logic       go;
	logic [2:0] kind;
	logic [7:0] obyte;
	logic       eng_done;
	logic [7:0] eng_rx;
	logic       eng_nack;
	logic [7:0] sel;
	logic       is_write;
	logic       valid_req;
	logic       is_i2c;
	logic [6:0] nbytes;
	logic [5:0] last_step;

	assign sel       = pkt[0] & 8'h0F;
	assign is_write  = (pkt[0] & ucb_pkg::OP_WRITE) != 8'h00;
	assign valid_req = (pkt[0] & 8'hE0) == 8'h00 && (sel == ucb_pkg::SEL_GPIO ||
		sel == ucb_pkg::SEL_SPI16 || sel == ucb_pkg::SEL_I2C_FAST ||
		sel == ucb_pkg::SEL_I2C_STANDARD_SELECT || sel == ucb_pkg::SEL_SPI8);
	assign is_i2c    = sel == ucb_pkg::SEL_I2C_STANDARD_SELECT || sel == ucb_pkg::SEL_I2C_FAST;
	assign nbytes    = pkt[2] > 8'(ucb_pkg::DATA_MAX) ? 7'(ucb_pkg::DATA_MAX) : pkt[2][6:0];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			armed <= 1'b0;
		end else if (setup_valid) begin
			armed <= setup_req_type == ucb_pkg::REQ_TYPE_CLASS_OUT &&
				setup_request == ucb_pkg::REQ_SET_REPORT &&
				setup_index == ucb_pkg::REQ_INDEX_IFACE;
		end else if (state == UCB_RECV && rx_valid && rx_last) begin
			armed <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (state == UCB_RECV && rx_valid && wr_idx < 7'(ucb_pkg::PKT_MAX)) begin
			pkt[wr_idx[5:0]] <= rx_data;
		end else if (eng_done && step >= 6'd2 && !is_write) begin
			pkt[6'(ucb_pkg::DATA_START) + step - 6'd2] <= eng_rx;
		end else if (state == UCB_RUN && sel == ucb_pkg::SEL_GPIO && !is_write) begin
			pkt[ucb_pkg::DATA_START] <= {1'b0, gpio_in};
		end else if (eng_done && step < 6'd2 && !is_i2c) begin
			pkt[step == 6'd0 ? 1 : 3] <= eng_rx;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer: I2C start, addr, reg, data, stop
	// ---------------------------------------------------------------
	always_comb begin
		last_step = 6'd1 + 6'(nbytes);
		kind      = 3'd5;
		obyte     = 8'h00;
		if (!is_i2c) begin
			obyte = step == 6'd0 ? pkt[1] : step == 6'd1 ? pkt[3] :
				is_write ? pkt[6'(ucb_pkg::DATA_START) + step - 6'd2] : 8'h00;
		end else begin
			kind  = step >= 6'd2 && !is_write ? (step == last_step ? 3'd4 : 3'd3) : 3'd2;
			obyte = step == 6'd0 ? {pkt[1][7:1], 1'b0} : step == 6'd1 ? pkt[3] :
				pkt[6'(ucb_pkg::DATA_START) + step - 6'd2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state    <= UCB_IDLE;
			wr_idx   <= 7'd0;
			rd_idx   <= 7'd0;
			tx_len   <= 7'd0;
			step     <= 6'd0;
			failed   <= 1'b0;
			go       <= 1'b0;
			spi_cs_n <= 1'b1;
			gpio_out <= 7'h00;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
			busy     <= 1'b0;
			rx_ready <= 1'b0;
		end else begin
			go <= 1'b0;
			unique case (state)
			UCB_IDLE: begin
				wr_idx <= 7'd0;
				busy   <= 1'b0;
				if (setup_valid) begin
					state    <= UCB_RECV;
					busy     <= 1'b1;
					rx_ready <= 1'b1;
				end
			end
			UCB_RECV: begin
				if (rx_valid) begin
					wr_idx <= wr_idx + 7'd1;
					if (rx_last) begin
						state  <= armed ? UCB_RUN : UCB_IDLE;
						rx_ready <= 1'b0;
						step   <= 6'd0;
						failed <= 1'b0;
					end
				end
			end
			UCB_RUN: begin
				if (!valid_req || sel == ucb_pkg::SEL_GPIO) begin
					if (valid_req && is_write) begin
						gpio_out <= pkt[ucb_pkg::DATA_START][6:0] & ucb_pkg::GPIO_MASK;
					end
					state <= UCB_SEND;
				end else begin
					spi_cs_n <= is_i2c;
					go       <= 1'b1;
					state    <= UCB_WAIT;
				end
				rd_idx <= 7'd0;
				tx_len <= 7'(ucb_pkg::DATA_START) +
					(sel == ucb_pkg::SEL_GPIO ? 7'd1 : nbytes);
			end
			UCB_WAIT: begin
				if (eng_done) begin
					if (eng_nack && is_i2c) begin
						failed <= 1'b1;
					end
					if (step == last_step || (eng_nack && is_i2c)) begin
						spi_cs_n <= 1'b1;
						state    <= UCB_SEND;
					end else begin
						step <= step + 6'd1;
						go   <= 1'b1;
					end
				end
			end
			UCB_SEND: begin
				if (!tx_valid || tx_ready) begin
					if (rd_idx == tx_len) begin
						tx_valid <= 1'b0;
						tx_last  <= 1'b0;
						state    <= UCB_IDLE;
					end else begin
						tx_valid <= 1'b1;
						tx_last  <= rd_idx == tx_len - 7'd1;
						tx_data  <= rd_idx != 7'd0 ? pkt[rd_idx[5:0]] :
							pkt[0] | (!valid_req ? ucb_pkg::FLAG_BAD_REQ :
							failed ? ucb_pkg::FLAG_BUS_FAIL : ucb_pkg::FLAG_DONE);
						rd_idx   <= rd_idx + 7'd1;
					end
				end
			end
			default: begin
				state    <= UCB_IDLE;
				rx_ready <= 1'b0;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Byte engine, wrapped in I2C start and stop by a small sub-sequence
	// ---------------------------------------------------------------
	logic [1:0] frame;
	logic       eng_go;
	logic [2:0] eng_kind;
	logic       eng_ack;
	logic       raw_done;

	// frame: 0 byte, 1 start in flight, 2 stop in flight, 3 stop done
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			frame <= 2'd0;
		end else if (go && is_i2c && step == 6'd0) begin
			frame <= 2'd1;
		end else if (raw_done && frame == 2'd1) begin
			frame <= 2'd0;
		end else if (raw_done && is_i2c && frame == 2'd0 &&
			(step == last_step || eng_nack)) begin
			frame <= 2'd2;
		end else if (raw_done && frame == 2'd2) begin
			frame <= 2'd3;
		end else if (frame == 2'd3) begin
			frame <= 2'd0;
		end
	end

	// Start goes out with the first go, stop right after the last byte or a nacked byte
	assign eng_kind = (go && is_i2c && step == 6'd0) ? 3'd0 :
		(raw_done && is_i2c && frame == 2'd0 && (step == last_step || eng_nack)) ? 3'd1 : kind;
	assign eng_go   = (go && !(is_i2c && step == 6'd0)) || (raw_done && frame != 2'd3 &&
		(frame == 2'd1 || (frame == 2'd0 && is_i2c && (step == last_step || eng_nack)))) ||
		(go && is_i2c && step == 6'd0);
	assign eng_ack  = is_i2c ? frame == 2'd3 || (raw_done && frame == 2'd0 &&
		step != last_step && !eng_nack) : raw_done;
	assign eng_done = eng_ack;

	ucb_serial_engine u_engine (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.cmd_go   (eng_go),
		.cmd_kind (eng_kind),
		.cmd_fast (sel == ucb_pkg::SEL_I2C_FAST),
		.cmd_byte (obyte),
		.cmd_done (raw_done),
		.cmd_rx   (eng_rx),
		.cmd_nack (eng_nack),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.scl_oe_n (scl_oe_n),
		.sda_oe_n (sda_oe_n),
		.spi_sclk (spi_sclk),
		.spi_mosi (spi_mosi),
		.spi_miso (spi_miso)
	);
endmodule

// [verification/ucb_target_model.sv]
`timescale 1ns/1ps
// Serial targets: I2C target answering one address, SPI target shifting a pattern
module ucb_target_model #(
	parameter logic [7:0] ADDR = 8'hA0,
	parameter logic [7:0] PAT  = 8'h3C
) (
	// I2C wires
	input  wire logic	scl,
	input  wire logic	sda,
	output logic		sda_rel,
	// SPI wires
	input  wire logic	spi_sclk,
	input  wire logic	spi_cs_n,
	input  wire logic	spi_mosi,
	output logic		spi_miso,
	output logic [15:0]	mosi_cmd,
	output logic [7:0]	mosi_n
);
	logic [7:0]	mi = 8'h00;
	int		mbits = 0;
	int		bits = 0;
	int		nbyte = 0;
	logic [7:0]	sh = 8'h00;
	logic [7:0]	so = PAT;

	initial sda_rel = 1'b1;
	initial begin
		mosi_cmd = 16'h0000;
		mosi_n = 8'h00;
	end
	always @(negedge sda) if (scl) begin
		bits = 0;
		nbyte = 0;
	end
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		bits = bits + 1;
	end
	// Acknowledge own address and every later byte, else leave released
	always @(negedge scl) begin
		sda_rel <= !(bits == 8 && (nbyte > 0 || sh[7:1] == ADDR[7:1]));
		if (bits == 9) begin
			bits = 0;
			nbyte = nbyte + 1;
		end
	end
	// Mode 0: next bit after each falling clock, inverse when deselected
	always @(negedge spi_cs_n) begin
		so = PAT;
		mbits = 0;
		mosi_n = 8'h00;
	end
	// Command word and byte count as seen on the data-in line
	always @(posedge spi_sclk) if (!spi_cs_n) begin
		mi = {mi[6:0], spi_mosi};
		mbits = mbits + 1;
		if (mbits == 8) begin
			mbits = 0;
			if (mosi_n == 8'h00)
				mosi_cmd[15:8] = mi;
			if (mosi_n == 8'h01)
				mosi_cmd[7:0] = mi;
			mosi_n = mosi_n + 8'h01;
		end
	end
	always @(negedge spi_sclk) if (!spi_cs_n) so = {so[6:0], so[7]};
	assign spi_miso = spi_cs_n ? ~so[7] : so[7];
endmodule

// [verification/ucb_command_bridge_sva.sv]
`timescale 1ns/1ps
module ucb_command_bridge_sva (
	// Clock and reset
	input wire logic	clk_sys,
	input wire logic	srst,
	// Request side
	input wire logic	setup_valid,
	input wire logic [7:0]	setup_req_type,
	input wire logic [7:0]	setup_request,
	input wire logic [7:0]	setup_index,
	input wire logic	rx_ready,
	// Response side
	input wire logic	tx_valid,
	input wire logic [7:0]	tx_data,
	input wire logic	tx_last,
	input wire logic	tx_ready,
	// Bus pins
	input wire logic	scl_oe_n,
	input wire logic	sda_oe_n,
	input wire logic	spi_cs_n,
	input wire logic	busy
);
	logic	at_first;
	logic	good;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	assign good = setup_req_type == 8'h21 && setup_request == 8'h09 && setup_index == 8'h03;
	always_ff @(posedge clk_sys) begin
		if (srst)
			at_first <= 1'b1;
		else if (tx_valid && tx_ready)
			at_first <= tx_last;
	end

	AST_RESET_IDLE: assert property ($fell(srst) |->
		!tx_valid && !busy && scl_oe_n && sda_oe_n && spi_cs_n) else $error("idle after reset");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("response moved");
	AST_IDLE_NO_BUS: assert property (!busy |->
		scl_oe_n && sda_oe_n && spi_cs_n) else $error("bus driven while idle");
	AST_CS_NO_TX: assert property (!spi_cs_n |-> !tx_valid)
		else $error("response during SPI frame");
	AST_SCL_NO_TX: assert property (!scl_oe_n |-> !tx_valid)
		else $error("response during I2C cycle");
	AST_RX_NO_TX: assert property (tx_valid |-> !rx_ready)
		else $error("request taken during response");
	AST_ONE_FLAG: assert property (tx_valid && at_first |-> $onehot(tx_data[7:5]))
		else $error("status flags not one-hot");
	AST_SETUP_TAKEN: assert property (setup_valid && good && !busy |-> ##[1:2] busy)
		else $error("setup not taken");

	COV_DONE: cover property (tx_valid && at_first && tx_data[5]);
	COV_FAIL: cover property (tx_valid && at_first && tx_data[6]);
	COV_BAD: cover property (tx_valid && at_first && tx_data[7]);
endmodule

// [verification/ucb_command_bridge_test.sv]
`timescale 1ns/1ps
module ucb_command_bridge_test;
	typedef logic [7:0] ucb_bytes_t [$];
	// Stimulus
	logic		clk_sys, srst, setup_valid, rx_valid, rx_last, tx_ready, bus_seen;
	logic [7:0]	setup_req_type, setup_request, setup_index, rx_data;
	logic [6:0]	gpio_in;
	// Observed
	wire logic	rx_ready, tx_valid, tx_last, scl_oe_n, sda_oe_n, spi_sclk, spi_mosi;
	wire logic	spi_cs_n, busy, sda_rel, spi_miso, scl, sda;
	wire logic [7:0] tx_data;
	wire logic [6:0] gpio_out;
	wire logic [7:0] mosi_n;
	wire logic [15:0] mosi_cmd;
	int		n_mismatch = 0;
	int		n_tests = 0;

	// Pull-ups on both I2C wires
	assign scl = scl_oe_n;
	assign sda = sda_oe_n & sda_rel;
	ucb_command_bridge ucb_command_bridge_inst (.clk_sys(clk_sys), .srst(srst),
		.setup_valid(setup_valid), .setup_req_type(setup_req_type),
		.setup_request(setup_request), .setup_index(setup_index), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .scl_in(scl),
		.sda_in(sda), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .busy(busy));
	ucb_target_model ucb_target_model_inst (.scl(scl), .sda(sda), .sda_rel(sda_rel),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.mosi_cmd(mosi_cmd), .mosi_n(mosi_n));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (!spi_cs_n || !sda_oe_n) bus_seen <= 1'b1;

	task automatic stop_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(inout int n);
		n++;
		if (n > 20000) begin
			n_mismatch++;
			stop_test();
		end
		@(negedge clk_sys);
	endtask
	task automatic send(input logic [7:0] idx, input ucb_bytes_t pk);
		int n;
		setup_valid = 1'b1;
		setup_index = idx;
		@(negedge clk_sys);
		setup_valid = 1'b0;
		setup_index = 8'h03;
		foreach (pk[i]) begin
			rx_valid = 1'b1;
			rx_data = pk[i];
			rx_last = (i == pk.size() - 1);
			n = 0;
			while (rx_ready !== 1'b1) tick(n);
			@(negedge clk_sys);
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
	endtask
	// One request, response taken with a stall cycle before every byte but the first
	task automatic run(input ucb_bytes_t pk, input ucb_bytes_t exp);
		ucb_bytes_t got;
		logic last;
		int n;
		send(8'h03, pk);
		do begin
			n = 0;
			while (tx_valid !== 1'b1) tick(n);
			got.push_back(tx_data);
			last = tx_last;
			tx_ready = 1'b1;
			@(negedge clk_sys);
			tx_ready = 1'b0;
			@(negedge clk_sys);
		end while (last !== 1'b1);
		chk("resp_len", 8'(exp.size()), 8'(got.size()));
		foreach (exp[i]) chk("resp_byte", exp[i], got[i]);
		n = 0;
		while (busy !== 1'b0) tick(n);
	endtask

	task automatic sc_gpio;
		run('{8'h18, 8'h00, 8'h01, 8'h00, 8'h40}, '{8'h38, 8'h00, 8'h01, 8'h00, 8'h40});
		chk("gpio_out", 8'h40, {1'b0, gpio_out});
		gpio_in = 7'h2A;
		run('{8'h08, 8'h00, 8'h01, 8'h00}, '{8'h28, 8'h00, 8'h01, 8'h00, 8'h2A});
	endtask
	task automatic sc_i2c;
		run('{8'h11, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55},
			'{8'h31, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55});
		run('{8'h12, 8'h90, 8'h01, 8'h07, 8'h3C},
			'{8'h52, 8'h90, 8'h01, 8'h07, 8'h3C});
	endtask
	task automatic sc_spi;
		run('{8'h10, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55},
			'{8'h30, 8'h3C, 8'h02, 8'h3C, 8'hAA, 8'h55});
		run('{8'h14, 8'h10, 8'h02, 8'hE0, 8'hAA, 8'h55},
			'{8'h34, 8'h3C, 8'h02, 8'h3C, 8'hAA, 8'h55});
		chk("spi_cmd_hi", 8'h10, mosi_cmd[15:8]);
		chk("spi_cmd_lo", 8'hE0, mosi_cmd[7:0]);
		chk("spi_count", 8'h04, mosi_n);
		run('{8'h00, 8'hA0, 8'h01, 8'h05}, '{8'h20, 8'h3C, 8'h01, 8'h3C, 8'h3C});
		chk("spi_count", 8'h03, mosi_n);
	endtask
	task automatic sc_bad;
		bus_seen = 1'b0;
		run('{8'h13, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55},
			'{8'h93, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55});
		chk("bus_used", 8'h00, {7'h00, bus_seen});
	endtask
	task automatic sc_refused;
		logic seen;
		int n;
		seen = 1'b0;
		bus_seen = 1'b0;
		send(8'h02, '{8'h11, 8'hA0, 8'h01, 8'h05, 8'h77});
		repeat (300) begin
			@(negedge clk_sys);
			seen = seen | tx_valid;
		end
		chk("refused_resp", 8'h00, {7'h00, seen});
		chk("refused_bus", 8'h00, {7'h00, bus_seen});
		n = 0;
		while (busy !== 1'b0) tick(n);
	endtask

	initial begin
		srst = 1'b1;
		setup_valid = 1'b0;
		setup_req_type = 8'h21;
		setup_request = 8'h09;
		setup_index = 8'h03;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b0;
		gpio_in = 7'h00;
		bus_seen = 1'b0;
		repeat (8) @(negedge clk_sys);
		srst = 1'b0;
		sc_gpio();
		sc_i2c();
		sc_spi();
		sc_bad();
		sc_refused();
		stop_test();
	end
endmodule

bind ucb_command_bridge ucb_command_bridge_sva ucb_command_bridge_sva_inst (
	.clk_sys(clk_sys), .srst(srst), .setup_valid(setup_valid),
	.setup_req_type(setup_req_type), .setup_request(setup_request),
	.setup_index(setup_index), .rx_ready(rx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .scl_oe_n(scl_oe_n),
	.sda_oe_n(sda_oe_n), .spi_cs_n(spi_cs_n), .busy(busy));
